/* File: dv/mdpo_top_assertions.sv */
`timescale 1ns/1ps
module mdpo_chk (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire mdpo_pkg::mdpo_obj_req_t obj_req_in, // Request
    input wire mdpo_pkg::mdpo_obj_rsp_t obj_rsp_out, // Answer
    input wire logic restart_in, // Restart pulse
    input wire logic setup_start_in, // Setup start
    input wire mdpo_pkg::mdpo_gains_t gains_out, // Gains
    input wire logic acc_ff_enable_out, // Accel ff on
    input wire logic vel_ff_unity_out, // Velocity ff is one
    input wire mdpo_pkg::mdpo_field_dir_t field_dir_out, // Field in force
    input wire logic setup_busy_out, // Setup running
    input wire logic setup_done_out, // Setup done
    input wire logic setup_needed_out // Setup owed
);
    // Reset outranks every check
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////
    // Setup run: taken, then busy, then done with busy low
    sequence s_take;
        setup_start_in && !setup_busy_out;
    endsequence
    sequence s_finish;
        setup_done_out && !setup_busy_out;
    endsequence
    a_setup_length: assert property (s_take |-> ##1 setup_busy_out ##50 s_finish)
        else $error("Setup run length wrong");
    a_done_pulse: assert property (setup_done_out |=> !setup_done_out)
        else $error("Done longer than one cycle");
    // Object port answers exactly one cycle after each request
    a_rsp_one_cycle: assert property (obj_req_in.valid |=> obj_rsp_out.valid)
        else $error("Missing answer");
    a_rsp_quiet: assert property (!obj_req_in.valid |=> !obj_rsp_out.valid)
        else $error("Answer without request");
    a_acc_ff_on: assert property (acc_ff_enable_out == (gains_out.acc_ff != 32'h0))
        else $error("Accel ff enable wrong");
    a_vel_unity: assert property (vel_ff_unity_out == (gains_out.vel_ff == 32'h3E8))
        else $error("Velocity unity flag wrong");
    // Field only moves on restart, which always leaves setup owed
    a_field_hold: assert property (!restart_in |=> $stable(field_dir_out))
        else $error("Field changed without restart");
    a_restart_owed: assert property (restart_in |=> setup_needed_out)
        else $error("Setup not owed after restart");
    a_ain_read_only: assert property (obj_req_in.valid && obj_req_in.write &&
        obj_req_in.index == mdpo_pkg::IDX_AIN |=> obj_rsp_out.error) else $error("Write taken");
endmodule

/* File: dv/mdpo_top_tb_top.sv */
`timescale 1ns/1ps
module mdpo_top_tb_top;
    typedef struct packed {
        logic w;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [31:0] wd;
        logic err;
        logic [31:0] rd;
    } mdpo_row_t;
    // Distinct from reset values so a preset load shows
    localparam logic [31:0] BLDC_P = 32'h00ABCDEF;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic restart_in = 1'b0;
    logic setup_start_in = 1'b0;
    logic motor_is_bldc_in = 1'b0;
    logic [31:0] adc_sample_in = 32'h0;
    logic [1:0] adc_valid_in = 2'h0;
    mdpo_pkg::mdpo_obj_req_t obj_req_in = '0;
    mdpo_pkg::mdpo_obj_rsp_t obj_rsp_out;
    mdpo_pkg::mdpo_gains_t gains_out;
    mdpo_pkg::mdpo_field_dir_t field_dir_out;
    logic acc_ff_enable_out, vel_ff_unity_out, keep_settings_out, setup_busy_out;
    logic setup_done_out, setup_needed_out;
    logic [1:0] ain_current_mode_out;
    logic [1:0] dirs [3] = '{2'h1, 2'h2, 2'h0};
    logic [31:0] codes [3] = '{32'h1, 32'hFF, 32'h0};
    int error_cnt = 0;
    int checked = 0;
    mdpo_row_t rows [12] = '{
        '{1'b0, 16'h3210, 8'h09, 32'h0, 1'b0, 32'h004DC880},
        '{1'b0, 16'h3210, 8'h0A, 32'h0, 1'b0, 32'h001D2B30},
        '{1'b0, 16'h3210, 8'h0B, 32'h0, 1'b0, 32'h3E8},
        '{1'b0, 16'h3210, 8'h0C, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h3220, 8'h00, 32'h0, 1'b0, 32'h2},
        '{1'b1, 16'h3220, 8'h01, 32'h5, 1'b1, 32'h0},
        '{1'b1, 16'h3212, 8'h02, 32'h5, 1'b1, 32'h0},
        '{1'b1, 16'h3210, 8'h09, 32'h12345678, 1'b0, 32'h0},
        '{1'b0, 16'h3210, 8'h09, 32'h0, 1'b0, 32'h12345678},
        '{1'b1, 16'h3210, 8'h0C, 32'h7, 1'b0, 32'h0},
        '{1'b1, 16'h3221, 8'h00, 32'h2, 1'b0, 32'h0},
        '{1'b0, 16'h3299, 8'h00, 32'h0, 1'b1, 32'h0}};
    mdpo_top #(.BLDC_OL_TQ_P(BLDC_P)) u_dut (.clk_in, .rst_n_in, .obj_req_in, .obj_rsp_out,
        .restart_in, .setup_start_in, .motor_is_bldc_in, .adc_sample_in, .adc_valid_in,
        .gains_out, .acc_ff_enable_out, .vel_ff_unity_out, .field_dir_out, .keep_settings_out,
        .ain_current_mode_out, .setup_busy_out, .setup_done_out, .setup_needed_out);
    initial
    begin
        forever #10 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge, outputs are read there too
    task automatic tick();
        @(posedge clk_in) #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Request held over one edge; the answer stands the cycle after
    task automatic acc(input mdpo_row_t r);
        tick();
        obj_req_in = '{1'b1, r.w, r.idx, r.sub, r.wd};
        tick();
        obj_req_in.valid = 1'b0;
        chk(obj_rsp_out.valid, 1'b1);
        chk(obj_rsp_out.error, r.err);
        chk(obj_rsp_out.rdata, r.rd);
    endtask
    // Bounded wait so a stuck setup cannot hang the run
    task automatic setup(input logic bldc);
        tick();
        motor_is_bldc_in = bldc;
        setup_start_in = 1'b1;
        tick();
        setup_start_in = 1'b0;
        for (int n = 0; setup_done_out !== 1'b1; n++)
        begin
            if (n > 99)
            begin
                error_cnt++;
                results();
            end
            tick();
        end
    endtask
    initial
    begin
        repeat (4) tick();
        rst_n_in = 1'b1;
        repeat (3) tick();
        foreach (rows[i])
            acc(rows[i]);
        chk(ain_current_mode_out, 2'h2);
        acc('{1'b1, 16'h3210, 8'h0B, 32'h1, 1'b0, 32'h0});
        for (int i = 0; i < 3; i++)
        begin
            acc('{1'b1, 16'h3212, 8'h02, codes[i], 1'b0, 32'h0});
            chk(field_dir_out, i ? dirs[i - 1] : 2'h0);
            restart_in = 1'b1;
            tick();
            restart_in = 1'b0;
            chk(field_dir_out, dirs[i]);
            chk(setup_needed_out, 1'b1);
        end
        acc('{1'b1, 16'h3212, 8'h03, 32'h1, 1'b0, 32'h0});
        chk(keep_settings_out, 1'b1);
        setup(1'b1);
        chk(gains_out.ol_tq_p, 32'h12345678);
        chk(setup_needed_out, 1'b0);
        acc('{1'b1, 16'h3212, 8'h03, 32'h0, 1'b0, 32'h0});
        setup(1'b1);
        chk(gains_out.ol_tq_p, BLDC_P);
        setup(1'b0);
        chk(gains_out.ol_tq_p, mdpo_pkg::RST_OL_TQ_P);
        adc_sample_in = 32'h80017FFE;
        adc_valid_in = 2'h3;
        tick();
        adc_valid_in = 2'h0;
        acc('{1'b0, 16'h3220, 8'h01, 32'h0, 1'b0, 32'h7FFE});
        acc('{1'b0, 16'h3220, 8'h02, 32'h0, 1'b0, 32'hFFFF8001});
        rst_n_in = 1'b0;
        #20;
        chk(gains_out.acc_ff, 32'h0);
        results();
    end
endmodule
bind mdpo_top mdpo_chk u_chk (.clk_in, .rst_n_in, .obj_req_in, .obj_rsp_out, .restart_in,
    .setup_start_in, .gains_out, .acc_ff_enable_out, .vel_ff_unity_out, .field_dir_out,
    .setup_busy_out, .setup_done_out, .setup_needed_out);

/* File: rtl/mdpo_ain_capture.sv */
`timescale 1ns/1ps
module mdpo_ain_capture #(
    parameter int CHANNELS = 2,
    parameter int WIDTH = 16
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronised reset, active low
    input wire logic [CHANNELS*WIDTH-1:0] sample_in, // Converter words
    input wire logic [CHANNELS-1:0] sample_valid_in, // One strobe per channel
    output logic [CHANNELS*WIDTH-1:0] value_out // Latest word per channel
);

    typedef struct packed {
        logic [CHANNELS-1:0][WIDTH-1:0] value;
    } mdpo_ain_state_t;

    mdpo_ain_state_t state_reg;
    mdpo_ain_state_t state_next;

    // Refuse shapes the object map cannot show
    if (CHANNELS < 1 || WIDTH < 1 || WIDTH > 32)
    begin : g_bad_shape
        $error("mdpo_ain_capture: unsupported channel count or width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Each channel holds its last word until its own strobe
    always_comb
    begin
        state_next = state_reg;
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            if (sample_valid_in[ch])
            begin
                state_next.value[ch] = sample_in[ch*WIDTH +: WIDTH];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign value_out = state_reg.value;

endmodule

/* File: rtl/mdpo_pkg.sv */
package mdpo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Object indices
    localparam logic [15:0] IDX_GAINS = 16'h3210;
    localparam logic [15:0] IDX_FLAGS = 16'h3212;
    localparam logic [15:0] IDX_AIN = 16'h3220;
    localparam logic [15:0] IDX_AIN_CTRL = 16'h3221;

    // Subindices
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_CL_TQ_I = 8'h08;
    localparam logic [7:0] SUB_OL_TQ_P = 8'h09;
    localparam logic [7:0] SUB_OL_TQ_I = 8'h0A;
    localparam logic [7:0] SUB_VEL_FF = 8'h0B;
    localparam logic [7:0] SUB_ACC_FF = 8'h0C;
    localparam logic [7:0] SUB_FLAGS_RSVD = 8'h01;
    localparam logic [7:0] SUB_FIELD = 8'h02;
    localparam logic [7:0] SUB_KEEP = 8'h03;
    localparam logic [7:0] SUB_AIN_ONE = 8'h01;
    localparam logic [7:0] SUB_AIN_TWO = 8'h02;

    ////////////////////////////////////////////////////////////////////////////
    // Entry counts and values after reset
    localparam logic [7:0] GAINS_COUNT = 8'h0C;
    localparam logic [7:0] FLAGS_COUNT = 8'h03;
    localparam logic [7:0] AIN_COUNT = 8'h02;
    localparam logic [31:0] RST_CL_TQ_I = 32'h0007C740;
    localparam logic [31:0] RST_OL_TQ_P = 32'h004DC880;
    localparam logic [31:0] RST_OL_TQ_I = 32'h001D2B30;
    localparam logic [31:0] RST_VEL_FF = 32'h000003E8;
    localparam logic [31:0] RST_ACC_FF = 32'h00000000;
    localparam logic [7:0] RST_FIELD = 8'h00;
    localparam logic [7:0] RST_KEEP = 8'h00;
    localparam logic [1:0] RST_AIN_CTRL = 2'h0;

    // Velocity feed-forward is in tenths of a percent
    localparam logic [31:0] VEL_FF_UNITY = 32'h000003E8;

    // Field override codes, signed 8-bit, and keep flag codes
    localparam logic [7:0] FIELD_FIRMWARE = 8'h00;
    localparam logic [7:0] FIELD_POSITIVE = 8'h01;
    localparam logic [7:0] FIELD_NEGATIVE = 8'hFF;
    localparam logic [7:0] KEEP_OFF = 8'h00;
    localparam logic [7:0] KEEP_ON = 8'h01;

    // Analog control: bit n selects current (1) or voltage (0) on input n+1
    localparam int AIN_CTRL_LSB = 0;
    localparam int AIN_CHANNELS = 2;
    localparam int AIN_WIDTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Auto setup run time
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETUP_TIME_NS = 1000;
    localparam logic [7:0] SETUP_CYCLES = 8'(SETUP_TIME_NS / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MDPO_DIR_FIRMWARE,
        MDPO_DIR_POSITIVE,
        MDPO_DIR_NEGATIVE
    } mdpo_field_dir_t;

    typedef enum logic [1:0] {
        MDPO_SETUP_IDLE,
        MDPO_SETUP_RUN
    } mdpo_setup_state_t;

    typedef enum logic [3:0] {
        MDPO_OBJ_NONE,
        MDPO_OBJ_GAINS_COUNT,
        MDPO_OBJ_CL_TQ_I,
        MDPO_OBJ_OL_TQ_P,
        MDPO_OBJ_OL_TQ_I,
        MDPO_OBJ_VEL_FF,
        MDPO_OBJ_ACC_FF,
        MDPO_OBJ_FLAGS_COUNT,
        MDPO_OBJ_FLAGS_RSVD,
        MDPO_OBJ_FIELD,
        MDPO_OBJ_KEEP,
        MDPO_OBJ_AIN_COUNT,
        MDPO_OBJ_AIN_ONE,
        MDPO_OBJ_AIN_TWO,
        MDPO_OBJ_AIN_CTRL
    } mdpo_obj_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } mdpo_obj_req_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [31:0] rdata;
    } mdpo_obj_rsp_t;

    typedef struct packed {
        logic [31:0] cl_tq_i;
        logic [31:0] ol_tq_p;
        logic [31:0] ol_tq_i;
        logic [31:0] vel_ff;
        logic [31:0] acc_ff;
    } mdpo_gains_t;

endpackage

/* File: rtl/mdpo_top.sv */
// Summary of operation
// - The velocity feed-forward factor counts tenths of a percent, 1000 meaning one.
// - Acceleration feed-forward starts at zero (off) and when nonzero acts in both directions.
// - Field override 0 means firmware default, 1 forces positive, -1 forces negative.
// - A field override write acts only after restart, and auto setup must then run again.
// - With keep flag 0, auto setup loads the preset set for the detected motor type.
// - With keep flag 1, auto setup uses the stored gains and leaves them unchanged.
// - Each analog input reads as a signed 16-bit ADC value and cannot be written.
// - The analog object reports two entries, one value per input.
// - The open-loop torque proportional gain is 32-bit read/write preset to 004DC880.
// - The open-loop torque integral gain is 32-bit read/write preset to 001D2B30.
// - Both analog inputs are set to current or voltage by one shared control object, one bit per input.
// - In the analog control object bit 0 sets input 1 and bit 1 sets input 2, 1 selecting current and 0 voltage.
`timescale 1ns/1ps
module mdpo_top #(
    parameter logic [31:0] BLDC_CL_TQ_I = 32'h00010000, // Brushless preset gains
    parameter logic [31:0] BLDC_OL_TQ_P = 32'h00100000,
    parameter logic [31:0] BLDC_OL_TQ_I = 32'h00010000
) (
    input wire logic clk_in, // 50 MHz clock
    input wire logic rst_n_in, // Async reset, active low
    input wire mdpo_pkg::mdpo_obj_req_t obj_req_in, // Object access request
    output mdpo_pkg::mdpo_obj_rsp_t obj_rsp_out, // Object access answer
    input wire logic restart_in, // Controller restart pulse
    input wire logic setup_start_in, // Auto setup start pulse
    input wire logic motor_is_bldc_in, // Detected motor type, 1 = brushless
    input wire logic [31:0] adc_sample_in, // Two 16-bit converter words
    input wire logic [1:0] adc_valid_in, // Per-channel sample strobes
    output mdpo_pkg::mdpo_gains_t gains_out, // Gains for the loops
    output logic acc_ff_enable_out, // Acceleration feed-forward active
    output logic vel_ff_unity_out, // Velocity factor equals one
    output mdpo_pkg::mdpo_field_dir_t field_dir_out, // Field direction in force
    output logic keep_settings_out, // Keep flag as stored
    output logic [1:0] ain_current_mode_out, // Per input: 1 current, 0 voltage
    output logic setup_busy_out, // Auto setup running
    output logic setup_done_out, // Auto setup finished pulse
    output logic setup_needed_out // Auto setup owed after restart
);

    typedef struct packed {
        mdpo_pkg::mdpo_obj_rsp_t rsp;
        mdpo_pkg::mdpo_gains_t gains;
        logic acc_ff_enable;
        logic vel_ff_unity;
        logic [7:0] field_override;
        mdpo_pkg::mdpo_field_dir_t field_active;
        logic [7:0] keep;
        logic [1:0] ain_ctrl;
        mdpo_pkg::mdpo_setup_state_t setup_state;
        logic [7:0] setup_cnt;
        logic setup_keep;
        logic setup_bldc;
        logic setup_busy;
        logic setup_done;
        logic setup_needed;
    } mdpo_state_t;

    mdpo_state_t state_reg;
    mdpo_state_t state_next;
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [31:0] ain_value;
    mdpo_pkg::mdpo_obj_t obj_sel;

    if (mdpo_pkg::SETUP_CYCLES < 8'h01)
    begin : g_bad_setup
        $error("mdpo_top: auto setup must last at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog readout latches
    mdpo_ain_capture #(
        .CHANNELS(mdpo_pkg::AIN_CHANNELS),
        .WIDTH(mdpo_pkg::AIN_WIDTH)
    ) u_ain (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_reg),
        .sample_in(adc_sample_in),
        .sample_valid_in(adc_valid_in),
        .value_out(ain_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Index and subindex to object; shared by read and write paths
    function automatic mdpo_pkg::mdpo_obj_t obj_lookup(
        input logic [15:0] index,
        input logic [7:0] sub
    );
        mdpo_pkg::mdpo_obj_t obj;
        obj = mdpo_pkg::MDPO_OBJ_NONE;
        case (index)
            mdpo_pkg::IDX_GAINS:
                case (sub)
                    mdpo_pkg::SUB_COUNT: obj = mdpo_pkg::MDPO_OBJ_GAINS_COUNT;
                    mdpo_pkg::SUB_CL_TQ_I: obj = mdpo_pkg::MDPO_OBJ_CL_TQ_I;
                    mdpo_pkg::SUB_OL_TQ_P: obj = mdpo_pkg::MDPO_OBJ_OL_TQ_P;
                    mdpo_pkg::SUB_OL_TQ_I: obj = mdpo_pkg::MDPO_OBJ_OL_TQ_I;
                    mdpo_pkg::SUB_VEL_FF: obj = mdpo_pkg::MDPO_OBJ_VEL_FF;
                    mdpo_pkg::SUB_ACC_FF: obj = mdpo_pkg::MDPO_OBJ_ACC_FF;
                    default: obj = mdpo_pkg::MDPO_OBJ_NONE;
                endcase
            mdpo_pkg::IDX_FLAGS:
                case (sub)
                    mdpo_pkg::SUB_COUNT: obj = mdpo_pkg::MDPO_OBJ_FLAGS_COUNT;
                    mdpo_pkg::SUB_FLAGS_RSVD: obj = mdpo_pkg::MDPO_OBJ_FLAGS_RSVD;
                    mdpo_pkg::SUB_FIELD: obj = mdpo_pkg::MDPO_OBJ_FIELD;
                    mdpo_pkg::SUB_KEEP: obj = mdpo_pkg::MDPO_OBJ_KEEP;
                    default: obj = mdpo_pkg::MDPO_OBJ_NONE;
                endcase
            mdpo_pkg::IDX_AIN:
                case (sub)
                    mdpo_pkg::SUB_COUNT: obj = mdpo_pkg::MDPO_OBJ_AIN_COUNT;
                    mdpo_pkg::SUB_AIN_ONE: obj = mdpo_pkg::MDPO_OBJ_AIN_ONE;
                    mdpo_pkg::SUB_AIN_TWO: obj = mdpo_pkg::MDPO_OBJ_AIN_TWO;
                    default: obj = mdpo_pkg::MDPO_OBJ_NONE;
                endcase
            mdpo_pkg::IDX_AIN_CTRL:
                if (sub == mdpo_pkg::SUB_COUNT)
                begin
                    obj = mdpo_pkg::MDPO_OBJ_AIN_CTRL;
                end
            default: obj = mdpo_pkg::MDPO_OBJ_NONE;
        endcase
        return obj;
    endfunction

    // Signed override code to the direction the loops use
    function automatic mdpo_pkg::mdpo_field_dir_t field_decode(input logic [7:0] code);
        mdpo_pkg::mdpo_field_dir_t dir;
        case (code)
            mdpo_pkg::FIELD_POSITIVE: dir = mdpo_pkg::MDPO_DIR_POSITIVE;
            mdpo_pkg::FIELD_NEGATIVE: dir = mdpo_pkg::MDPO_DIR_NEGATIVE;
            default: dir = mdpo_pkg::MDPO_DIR_FIRMWARE;
        endcase
        return dir;
    endfunction

    assign obj_sel = obj_lookup(obj_req_in.index, obj_req_in.sub);

    ////////////////////////////////////////////////////////////////////////////
    // Next state: object access, restart, auto setup
    always_comb
    begin
        state_next = state_reg;
        state_next.rsp = '0;
        state_next.setup_done = 1'b0;

        // Object access, answered one cycle after the request
        if (obj_req_in.valid)
        begin
            state_next.rsp.valid = 1'b1;
            if (obj_req_in.write)
            begin
                case (obj_sel)
                    mdpo_pkg::MDPO_OBJ_CL_TQ_I:
                        state_next.gains.cl_tq_i = obj_req_in.wdata;
                    mdpo_pkg::MDPO_OBJ_OL_TQ_P:
                        state_next.gains.ol_tq_p = obj_req_in.wdata;
                    mdpo_pkg::MDPO_OBJ_OL_TQ_I:
                        state_next.gains.ol_tq_i = obj_req_in.wdata;
                    mdpo_pkg::MDPO_OBJ_VEL_FF:
                        state_next.gains.vel_ff = obj_req_in.wdata;
                    mdpo_pkg::MDPO_OBJ_ACC_FF:
                        state_next.gains.acc_ff = obj_req_in.wdata;
                    mdpo_pkg::MDPO_OBJ_FLAGS_RSVD:
                        state_next.rsp.error = 1'b0; // Accepted, no effect
                    mdpo_pkg::MDPO_OBJ_FIELD:
                        // Stored only; the loops see it after restart
                        if (obj_req_in.wdata[7:0] == mdpo_pkg::FIELD_FIRMWARE
                            || obj_req_in.wdata[7:0] == mdpo_pkg::FIELD_POSITIVE
                            || obj_req_in.wdata[7:0] == mdpo_pkg::FIELD_NEGATIVE)
                        begin
                            state_next.field_override = obj_req_in.wdata[7:0];
                        end
                        else
                        begin
                            state_next.rsp.error = 1'b1;
                        end
                    mdpo_pkg::MDPO_OBJ_KEEP:
                        if (obj_req_in.wdata[7:0] == mdpo_pkg::KEEP_OFF
                            || obj_req_in.wdata[7:0] == mdpo_pkg::KEEP_ON)
                        begin
                            state_next.keep = obj_req_in.wdata[7:0];
                        end
                        else
                        begin
                            state_next.rsp.error = 1'b1;
                        end
                    mdpo_pkg::MDPO_OBJ_AIN_CTRL:
                        state_next.ain_ctrl =
                            obj_req_in.wdata[mdpo_pkg::AIN_CTRL_LSB +: 2];
                    default:
                        state_next.rsp.error = 1'b1;
                endcase
            end
            else
            begin
                case (obj_sel)
                    mdpo_pkg::MDPO_OBJ_GAINS_COUNT:
                        state_next.rsp.rdata = {24'h000000, mdpo_pkg::GAINS_COUNT};
                    mdpo_pkg::MDPO_OBJ_CL_TQ_I:
                        state_next.rsp.rdata = state_reg.gains.cl_tq_i;
                    mdpo_pkg::MDPO_OBJ_OL_TQ_P:
                        state_next.rsp.rdata = state_reg.gains.ol_tq_p;
                    mdpo_pkg::MDPO_OBJ_OL_TQ_I:
                        state_next.rsp.rdata = state_reg.gains.ol_tq_i;
                    mdpo_pkg::MDPO_OBJ_VEL_FF:
                        state_next.rsp.rdata = state_reg.gains.vel_ff;
                    mdpo_pkg::MDPO_OBJ_ACC_FF:
                        state_next.rsp.rdata = state_reg.gains.acc_ff;
                    mdpo_pkg::MDPO_OBJ_FLAGS_COUNT:
                        state_next.rsp.rdata = {24'h000000, mdpo_pkg::FLAGS_COUNT};
                    mdpo_pkg::MDPO_OBJ_FLAGS_RSVD:
                        state_next.rsp.rdata = 32'h00000000;
                    mdpo_pkg::MDPO_OBJ_FIELD:
                        // Signed 8-bit object, sign-extended
                        state_next.rsp.rdata = {{24{state_reg.field_override[7]}},
                                                state_reg.field_override};
                    mdpo_pkg::MDPO_OBJ_KEEP:
                        state_next.rsp.rdata = {24'h000000, state_reg.keep};
                    mdpo_pkg::MDPO_OBJ_AIN_COUNT:
                        state_next.rsp.rdata = {24'h000000, mdpo_pkg::AIN_COUNT};
                    mdpo_pkg::MDPO_OBJ_AIN_ONE:
                        state_next.rsp.rdata = {{16{ain_value[15]}}, ain_value[15:0]};
                    mdpo_pkg::MDPO_OBJ_AIN_TWO:
                        state_next.rsp.rdata = {{16{ain_value[31]}}, ain_value[31:16]};
                    mdpo_pkg::MDPO_OBJ_AIN_CTRL:
                        state_next.rsp.rdata = {30'h00000000, state_reg.ain_ctrl};
                    default:
                        state_next.rsp.error = 1'b1;
                endcase
            end
        end

        // Auto setup: keep flag and motor type are caught at start
        case (state_reg.setup_state)
            mdpo_pkg::MDPO_SETUP_IDLE:
                if (setup_start_in)
                begin
                    state_next.setup_state = mdpo_pkg::MDPO_SETUP_RUN;
                    state_next.setup_cnt = mdpo_pkg::SETUP_CYCLES;
                    state_next.setup_keep = (state_reg.keep == mdpo_pkg::KEEP_ON);
                    state_next.setup_bldc = motor_is_bldc_in;
                    state_next.setup_busy = 1'b1;
                end
            mdpo_pkg::MDPO_SETUP_RUN:
                if (state_reg.setup_cnt == 8'h01)
                begin
                    state_next.setup_state = mdpo_pkg::MDPO_SETUP_IDLE;
                    state_next.setup_cnt = 8'h00;
                    state_next.setup_busy = 1'b0;
                    state_next.setup_done = 1'b1;
                    state_next.setup_needed = 1'b0;
                    // Preset load wins over a same-cycle gain write
                    if (!state_reg.setup_keep && state_reg.setup_bldc)
                    begin
                        state_next.gains.cl_tq_i = BLDC_CL_TQ_I;
                        state_next.gains.ol_tq_p = BLDC_OL_TQ_P;
                        state_next.gains.ol_tq_i = BLDC_OL_TQ_I;
                    end
                    else if (!state_reg.setup_keep)
                    begin
                        state_next.gains.cl_tq_i = mdpo_pkg::RST_CL_TQ_I;
                        state_next.gains.ol_tq_p = mdpo_pkg::RST_OL_TQ_P;
                        state_next.gains.ol_tq_i = mdpo_pkg::RST_OL_TQ_I;
                    end
                    // Keep set: gains are left exactly as stored
                end
                else
                begin
                    state_next.setup_cnt = state_reg.setup_cnt - 8'h01;
                end
            default:
                state_next.setup_state = mdpo_pkg::MDPO_SETUP_IDLE;
        endcase

        // Restart applies the override; set beats a same-cycle setup finish
        if (restart_in)
        begin
            state_next.field_active = field_decode(state_next.field_override);
            state_next.setup_needed = 1'b1;
        end

        // Flags the loops read, derived from the next gain values
        state_next.acc_ff_enable = (state_next.gains.acc_ff != 32'h00000000);
        state_next.vel_ff_unity = (state_next.gains.vel_ff == mdpo_pkg::VEL_FF_UNITY);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_in or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg <= '0;
            state_reg.gains.cl_tq_i <= mdpo_pkg::RST_CL_TQ_I;
            state_reg.gains.ol_tq_p <= mdpo_pkg::RST_OL_TQ_P;
            state_reg.gains.ol_tq_i <= mdpo_pkg::RST_OL_TQ_I;
            state_reg.gains.vel_ff <= mdpo_pkg::RST_VEL_FF;
            state_reg.gains.acc_ff <= mdpo_pkg::RST_ACC_FF;
            state_reg.vel_ff_unity <= 1'b1;
            state_reg.field_override <= mdpo_pkg::RST_FIELD;
            state_reg.field_active <= mdpo_pkg::MDPO_DIR_FIRMWARE;
            state_reg.keep <= mdpo_pkg::RST_KEEP;
            state_reg.ain_ctrl <= mdpo_pkg::RST_AIN_CTRL;
            state_reg.setup_state <= mdpo_pkg::MDPO_SETUP_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register
    assign obj_rsp_out = state_reg.rsp;
    assign gains_out = state_reg.gains;
    assign acc_ff_enable_out = state_reg.acc_ff_enable;
    assign vel_ff_unity_out = state_reg.vel_ff_unity;
    assign field_dir_out = state_reg.field_active;
    assign keep_settings_out = state_reg.keep[0];
    assign ain_current_mode_out = state_reg.ain_ctrl;
    assign setup_busy_out = state_reg.setup_busy;
    assign setup_done_out = state_reg.setup_done;
    assign setup_needed_out = state_reg.setup_needed;

endmodule
